// >>> hw/lccc_defs.vh
`ifndef LCCC_DEFS_VH
`define LCCC_DEFS_VH

// apb byte addresses
`define LCCC_ADDR_SHARED  32'h1008_4400
`define LCCC_ADDR_PTR     32'h1008_4404

// register pointer codes
`define LCCC_PTR_CSR0     2'h0
`define LCCC_PTR_CSR1     2'h1
`define LCCC_PTR_CSR2     2'h2
`define LCCC_PTR_CSR3     2'h3
`define LCCC_PTR_RESET    2'h0

// command and status bit positions
`define LCCC_B_INIT       0
`define LCCC_B_START_COMMAND       1
`define LCCC_B_STOP       2
`define LCCC_B_TRANSMIT_DEMAND       3
`define LCCC_B_TRANSMITTER_ENABLED       4
`define LCCC_B_RECEIVER_ENABLED       5
`define LCCC_B_INITIALIZATION_DONE       8
`define LCCC_B_MEMORY_ERROR       11

// transmit descriptor word 2 error bits
`define LCCC_B_TRANSMIT_UNDERFLOW       31
`define LCCC_B_TRANSMIT_BUFFER_ERROR       30
`define LCCC_B_TRANSMIT_RETRY_ERROR       26

// mode word bits
`define LCCC_MODE_DRX     0
`define LCCC_MODE_DTX     1

// widths and reset values
`define LCCC_HI_W         8
`define LCCC_BCFG_W       4
`define LCCC_ZERO32       32'h0000_0000
`define LCCC_ZERO16       16'h0000
`define LCCC_ZERO8        8'h00
`define LCCC_ZERO4        4'h0

// initialization block fetch
`define LCCC_IB_LAST      4'hb
`define LCCC_WORD_STEP    24'h00_0002
`define LCCC_TMO_CYCLES   10'h200 // 25.6 us of 50 ns cycles

// ring poll interval in cycles
`define LCCC_POLL_CYCLES  16'h0400

`endif

// >>> hw/lccc_ibfetch.v
`include "lccc_defs.vh"

// initialization block reader: twelve words by dma, keeps the mode word
module lccc_ibfetch #(
	parameter [9:0] TMO_CYCLES = `LCCC_TMO_CYCLES
) (
	input  wire        clock,
	input  wire        nrst,
	input  wire        start,
	input  wire        abort,
	input  wire [23:0] base_addr,
	input  wire        mem_ack,
	input  wire [15:0] mem_rdata,
	output reg         mem_req_ff,
	output reg  [23:0] mem_addr_ff,
	output reg  [15:0] mode_ff,
	output reg         done_ff,
	output reg         err_ff
);
	localparam [1:0] ST_IDLE  = 2'h1;
	localparam [1:0] ST_FETCH = 2'h2;
	localparam [9:0] TMO_LAST = TMO_CYCLES - 10'h001;

	reg [1:0]  state_ff;
	reg [3:0]  idx_ff;
	reg [9:0]  tmo_ff;
	reg [1:0]  nxt_state;
	reg [3:0]  nxt_idx;
	reg [9:0]  nxt_tmo;
	reg        nxt_req;
	reg [23:0] nxt_addr;
	reg [15:0] nxt_mode;
	reg        nxt_done;
	reg        nxt_err;

	// fetch sequencing, abort and memory timeout
	always @* begin
		nxt_state = state_ff;
		nxt_idx   = idx_ff;
		nxt_tmo   = tmo_ff;
		nxt_req   = mem_req_ff;
		nxt_addr  = mem_addr_ff;
		nxt_mode  = mode_ff;
		nxt_done  = 1'b0;
		nxt_err   = 1'b0;
		if (abort) begin
			nxt_state = ST_IDLE;
			nxt_req   = 1'b0;
		end else begin
			case (state_ff)
			ST_IDLE: begin
				if (start) begin
					nxt_state = ST_FETCH;
					nxt_req   = 1'b1;
					nxt_addr  = base_addr;
					nxt_idx   = `LCCC_ZERO4;
					nxt_tmo   = 10'h000;
				end
			end
			ST_FETCH: begin
				if (mem_ack) begin
					nxt_tmo = 10'h000;
					if (idx_ff == `LCCC_ZERO4)
						nxt_mode = mem_rdata; // mode word
					if (idx_ff == `LCCC_IB_LAST) begin
						nxt_req   = 1'b0;
						nxt_done  = 1'b1;
						nxt_state = ST_IDLE;
					end else begin
						nxt_idx  = idx_ff + 4'h1;
						nxt_addr = mem_addr_ff + `LCCC_WORD_STEP;
					end
				end else if (tmo_ff == TMO_LAST) begin
					nxt_req   = 1'b0;
					nxt_err   = 1'b1; // no ready in time
					nxt_state = ST_IDLE;
				end else begin
					nxt_tmo = tmo_ff + 10'h001;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_req   = 1'b0;
			end
			endcase
		end
	end

	// state registers
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_ff    <= ST_IDLE;
			idx_ff      <= `LCCC_ZERO4;
			tmo_ff      <= 10'h000;
			mem_req_ff  <= 1'b0;
			mem_addr_ff <= 24'h00_0000;
			mode_ff     <= `LCCC_ZERO16;
			done_ff     <= 1'b0;
			err_ff      <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			idx_ff      <= nxt_idx;
			tmo_ff      <= nxt_tmo;
			mem_req_ff  <= nxt_req;
			mem_addr_ff <= nxt_addr;
			mode_ff     <= nxt_mode;
			done_ff     <= nxt_done;
			err_ff      <= nxt_err;
		end
	end
endmodule // lccc_ibfetch

// >>> hw/lccc_poll.v
`include "lccc_defs.vh"

// transmit ring poll timer with immediate demand
module lccc_poll #(
	parameter [15:0] POLL_CYCLES = `LCCC_POLL_CYCLES
) (
	input  wire clock,
	input  wire nrst,
	input  wire enable,
	input  wire demand,
	output reg  poll_ff,
	output reg  ack_ff
);
	localparam [15:0] POLL_LAST = POLL_CYCLES - 16'h0001;

	reg [15:0] cnt_ff;
	reg [15:0] nxt_cnt;
	reg        nxt_poll;
	reg        nxt_ack;

	// demand overrides the interval; ack guard avoids a double poll
	always @* begin
		nxt_cnt  = cnt_ff + 16'h0001;
		nxt_poll = 1'b0;
		nxt_ack  = 1'b0;
		if (!enable) begin
			nxt_cnt = `LCCC_ZERO16;
		end else if (demand && !ack_ff) begin
			nxt_poll = 1'b1;
			nxt_ack  = 1'b1;
			nxt_cnt  = `LCCC_ZERO16;
		end else if (cnt_ff == POLL_LAST) begin
			nxt_poll = 1'b1;
			nxt_cnt  = `LCCC_ZERO16;
		end
	end

	// timer registers
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_ff  <= `LCCC_ZERO16;
			poll_ff <= 1'b0;
			ack_ff  <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			poll_ff <= nxt_poll;
			ack_ff  <= nxt_ack;
		end
	end
endmodule // lccc_poll

// >>> hw/lccc_top.v
// Functional notes
// - start after init done turns receiver on unless mode disables it
// - receiver status clears on stop, memory error and resets
// - start after init done turns transmitter on unless mode disables it
// - transmitter status clears on stop, memory error, resets, tx errors
// - receiver and transmitter status bits ignore software writes
// - transmit demand polls the transmit ring immediately; here only while the transmitter is on, else it waits
// - device clears demand on recognition; zero writes ignored
// - stop halts external activity and resets internal logic
// - stop clears every other command and status bit
// - stop written with init and start wins; neither is set
// - stop set at reset, cleared by init or start, zero ignored
// - address and bus configuration registers reachable only when stopped
// - start enables traffic and dma; needs stop first; zero ignored
// - init fetches the block by dma from the programmed address
// - low address register holds bits 15:0 as written; bit 0 is forced even only in the fetch address
// - low address register is 16 bits at pointer code 01
// - init done flag sets when the block has been read
// - high address register supplies bits 23:16 of the block
`include "lccc_defs.vh"

module lccc_top #(
	parameter [15:0] POLL_CYCLES = `LCCC_POLL_CYCLES
) (
	input  wire        clock,
	input  wire        nrst,
	input  wire        io_reset_a,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output wire        mem_req,
	output wire [23:0] mem_addr,
	input  wire        mem_ack,
	input  wire [15:0] mem_rdata,
	input  wire        mem_error,
	input  wire        tx_status_valid,
	input  wire [31:0] transmit_descriptor_word2,
	output wire        receiver_enabled,
	output wire        transmitter_enabled,
	output wire        tx_ring_poll,
	output wire        controller_running,
	output wire        controller_stopped,
	output wire [3:0]  bus_configuration
);
	// one-hot register select {csr3, csr2, csr1, csr0, pointer}
	function [4:0] reg_decode;
		input [31:0] addr;
		input [1:0]  ptr;
		begin
			reg_decode = 5'h00;
			if (addr == `LCCC_ADDR_PTR)
				reg_decode[0] = 1'b1;
			else if (addr == `LCCC_ADDR_SHARED)
				reg_decode[{1'b0, ptr} + 3'h1] = 1'b1;
		end
	endfunction

	// command bit written as one; a stop in the same word vetoes it
	function cmd_set;
		input         wr;
		input [15:0]  data;
		input integer pos;
		begin
			cmd_set = wr & data[pos] & ~data[`LCCC_B_STOP];
		end
	endfunction

	reg        stop_ff;
	reg        start_command_ff;
	reg        init_ff;
	reg        transmit_demand_ff;
	reg        receiver_enabled_ff;
	reg        transmitter_enabled_ff;
	reg        initialization_done_ff;
	reg        memory_error_ff;
	reg        ready_ok_ff;
	reg        init_go_ff;
	reg [1:0]  ptr_ff;
	reg [15:0] addr_lo_ff;
	reg [7:0]  addr_hi_ff;
	reg [3:0]  bcfg_ff;
	reg        nxt_stop;
	reg        nxt_start_command;
	reg        nxt_init;
	reg        nxt_transmit_demand;
	reg        nxt_receiver_enabled;
	reg        nxt_transmitter_enabled;
	reg        nxt_initialization_done;
	reg        nxt_memory_error;
	reg        nxt_ready_ok;
	reg [31:0] nxt_rdata;

	wire [15:0] mode_word;
	wire        ib_done;
	wire        ib_err;
	wire        poll_ack;

	// apb phases: answer one cycle into the access, commit on the edge that ends the ready cycle
	wire        access   = psel & penable & ~pready;
	wire        commit   = psel & penable & pready;
	wire [4:0]  rsel     = reg_decode(paddr, ptr_ff);
	wire        do_wr    = commit & pwrite & ~pslverr;
	wire [15:0] wd       = pwdata[15:0];
	wire        csr0_wr  = do_wr & rsel[1];
	wire        cfg_wr   = do_wr & stop_ff;

	// decoded command strobes
	wire wr_stop = csr0_wr & wd[`LCCC_B_STOP] | io_reset_a;
	wire wr_init = cmd_set(csr0_wr, wd, `LCCC_B_INIT);
	wire wr_start_command = cmd_set(csr0_wr, wd, `LCCC_B_START_COMMAND);
	wire wr_transmit_demand = cmd_set(csr0_wr, wd, `LCCC_B_TRANSMIT_DEMAND);

	// event sources
	wire memory_error_evt = ib_err | mem_error;
	wire tx_err_evt = tx_status_valid &
		(transmit_descriptor_word2[`LCCC_B_TRANSMIT_UNDERFLOW] |
		 transmit_descriptor_word2[`LCCC_B_TRANSMIT_BUFFER_ERROR] |
		 transmit_descriptor_word2[`LCCC_B_TRANSMIT_RETRY_ERROR]);

	// enable request: start after init done, whichever comes last
	reg en_evt;
	always @* begin
		en_evt = 1'b0;
		if (wr_start_command & (ready_ok_ff | ib_done))
			en_evt = 1'b1;
		if (ib_done & start_command_ff)
			en_evt = 1'b1; // start already given
	end

	// command bit next values
	always @* begin
		nxt_stop = stop_ff;
		nxt_start_command = start_command_ff;
		nxt_init = init_ff;
		if (wr_stop) begin
			nxt_stop = 1'b1;
			nxt_start_command = 1'b0;
			nxt_init = 1'b0;
		end else begin
			if (wr_init)
				nxt_init = 1'b1;
			if (wr_start_command)
				nxt_start_command = 1'b1;
			if (wr_init | wr_start_command)
				nxt_stop = 1'b0;
		end
	end

	// status bits and sticky flags
	always @* begin
		nxt_receiver_enabled     = receiver_enabled_ff;
		nxt_transmitter_enabled     = transmitter_enabled_ff;
		nxt_initialization_done     = initialization_done_ff;
		nxt_memory_error     = memory_error_ff;
		nxt_ready_ok = ready_ok_ff;
		nxt_transmit_demand     = transmit_demand_ff;
		if (wr_stop) begin
			nxt_receiver_enabled     = 1'b0;
			nxt_transmitter_enabled     = 1'b0;
			nxt_initialization_done     = 1'b0;
			nxt_memory_error     = 1'b0;
			nxt_ready_ok = 1'b0;
			nxt_transmit_demand     = 1'b0;
		end else begin
			// write one to clear, a new event wins
			if (csr0_wr & wd[`LCCC_B_INITIALIZATION_DONE])
				nxt_initialization_done = 1'b0;
			if (ib_done)
				nxt_initialization_done = 1'b1;
			if (csr0_wr & wd[`LCCC_B_MEMORY_ERROR])
				nxt_memory_error = 1'b0;
			if (memory_error_evt)
				nxt_memory_error = 1'b1;
			if (wr_init)
				nxt_ready_ok = 1'b0;
			if (ib_done)
				nxt_ready_ok = 1'b1;
			// enables follow start after init, never a direct write
			if (en_evt) begin
				nxt_receiver_enabled = ~mode_word[`LCCC_MODE_DRX];
				nxt_transmitter_enabled = ~mode_word[`LCCC_MODE_DTX];
			end
			if (memory_error_evt) begin
				nxt_receiver_enabled = 1'b0;
				nxt_transmitter_enabled = 1'b0;
			end
			if (tx_err_evt)
				nxt_transmitter_enabled = 1'b0;
			// demand: hardware clears on ack, a new write wins
			if (poll_ack)
				nxt_transmit_demand = 1'b0;
			if (wr_transmit_demand)
				nxt_transmit_demand = 1'b1;
		end
	end

	// command and status registers, stop set from power-up
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stop_ff     <= 1'b1;
			start_command_ff     <= 1'b0;
			init_ff     <= 1'b0;
			transmit_demand_ff     <= 1'b0;
			receiver_enabled_ff     <= 1'b0;
			transmitter_enabled_ff     <= 1'b0;
			initialization_done_ff     <= 1'b0;
			memory_error_ff     <= 1'b0;
			ready_ok_ff <= 1'b0;
		end else begin
			stop_ff     <= nxt_stop;
			start_command_ff     <= nxt_start_command;
			init_ff     <= nxt_init;
			transmit_demand_ff     <= nxt_transmit_demand;
			receiver_enabled_ff     <= nxt_receiver_enabled;
			transmitter_enabled_ff     <= nxt_transmitter_enabled;
			initialization_done_ff     <= nxt_initialization_done;
			memory_error_ff     <= nxt_memory_error;
			ready_ok_ff <= nxt_ready_ok;
		end
	end

	// one-cycle fetch launch after an init write
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			init_go_ff <= 1'b0;
		else
			init_go_ff <= wr_init & ~wr_stop;
	end

	// register pointer, writable at any time
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			ptr_ff <= `LCCC_PTR_RESET;
		else if (io_reset_a)
			ptr_ff <= `LCCC_PTR_RESET;
		else if (do_wr & rsel[0])
			ptr_ff <= pwdata[1:0];
	end

	// init block address, only while stopped
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			addr_lo_ff <= `LCCC_ZERO16;
			addr_hi_ff <= `LCCC_ZERO8;
		end else begin
			if (cfg_wr & rsel[2])
				addr_lo_ff <= wd;
			if (cfg_wr & rsel[3])
				addr_hi_ff <= wd[`LCCC_HI_W-1:0];
		end
	end

	// bus configuration, cleared by stop
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			bcfg_ff <= `LCCC_ZERO4;
		else if (wr_stop)
			bcfg_ff <= `LCCC_ZERO4;
		else if (cfg_wr & rsel[4])
			bcfg_ff <= wd[`LCCC_BCFG_W-1:0];
	end

	// read mux; address registers read zero while running
	always @* begin
		nxt_rdata = `LCCC_ZERO32;
		if (rsel[0])
			nxt_rdata[1:0] = ptr_ff;
		if (rsel[1]) begin
			nxt_rdata[`LCCC_B_INIT] = init_ff;
			nxt_rdata[`LCCC_B_START_COMMAND] = start_command_ff;
			nxt_rdata[`LCCC_B_STOP] = stop_ff;
			nxt_rdata[`LCCC_B_TRANSMIT_DEMAND] = transmit_demand_ff;
			nxt_rdata[`LCCC_B_TRANSMITTER_ENABLED] = transmitter_enabled_ff;
			nxt_rdata[`LCCC_B_RECEIVER_ENABLED] = receiver_enabled_ff;
			nxt_rdata[`LCCC_B_INITIALIZATION_DONE] = initialization_done_ff;
			nxt_rdata[`LCCC_B_MEMORY_ERROR] = memory_error_ff;
		end
		if (rsel[2] & stop_ff)
			nxt_rdata[15:0] = addr_lo_ff;
		if (rsel[3] & stop_ff)
			nxt_rdata[`LCCC_HI_W-1:0] = addr_hi_ff;
		if (rsel[4] & stop_ff)
			nxt_rdata[`LCCC_BCFG_W-1:0] = bcfg_ff;
	end

	// apb answer registers; unmapped addresses give an error
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prdata  <= `LCCC_ZERO32;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (access) begin
			prdata  <= pwrite ? `LCCC_ZERO32 : nxt_rdata;
			pready  <= 1'b1;
			pslverr <= ~(|rsel);
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// block fetch engine, bit 0 forced even
	lccc_ibfetch u_ibfetch (
		.clock      (clock),
		.nrst       (nrst),
		.start      (init_go_ff),
		.abort      (wr_stop),
		.base_addr  ({addr_hi_ff, addr_lo_ff[15:1], 1'b0}),
		.mem_ack    (mem_ack),
		.mem_rdata  (mem_rdata),
		.mem_req_ff (mem_req),
		.mem_addr_ff(mem_addr),
		.mode_ff    (mode_word),
		.done_ff    (ib_done),
		.err_ff     (ib_err)
	);

	// transmit ring polling while the transmitter is on
	lccc_poll #(
		.POLL_CYCLES(POLL_CYCLES)
	) u_poll (
		.clock  (clock),
		.nrst   (nrst),
		.enable (transmitter_enabled_ff),
		.demand (transmit_demand_ff),
		.poll_ff(tx_ring_poll),
		.ack_ff (poll_ack)
	);

	// status outputs straight from flops
	assign receiver_enabled    = receiver_enabled_ff;
	assign transmitter_enabled = transmitter_enabled_ff;
	assign controller_running  = start_command_ff;
	assign controller_stopped  = stop_ff;
	assign bus_configuration   = bcfg_ff;
endmodule // lccc_top

// >>> tb/lccc_chk.sv
`include "lccc_defs.vh"

module lccc_chk #(
	parameter [15:0] POLL_CYCLES = 16'h0400
) (
	input wire        clock,
	input wire        nrst,
	input wire        io_reset_a,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire        mem_req,
	input wire [23:0] mem_addr,
	input wire        mem_error,
	input wire        tx_status_valid,
	input wire [31:0] transmit_descriptor_word2,
	input wire        receiver_enabled,
	input wire        transmitter_enabled,
	input wire        tx_ring_poll,
	input wire        controller_running,
	input wire        controller_stopped
);
	timeunit 1ns;
	timeprecision 1ns;
	reg  [1:0]  ptr_ff;
	wire        acc = psel && penable && pready && pwrite;
	wire        wr0 = acc && paddr == `LCCC_ADDR_SHARED && ptr_ff == 2'h0;
	wire [31:0] w2  = transmit_descriptor_word2;

	// shadow of the register pointer
	always @(posedge clock or negedge nrst) begin
		if (!nrst)
			ptr_ff <= 2'h0;
		else if (io_reset_a)
			ptr_ff <= 2'h0;
		else if (acc && paddr == `LCCC_ADDR_PTR)
			ptr_ff <= pwdata[1:0];
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	stop_clears_a: assert property (controller_stopped |->
		!(receiver_enabled || transmitter_enabled || controller_running))
		else $error("status set while stopped");
	stop_wins_a: assert property (wr0 && pwdata[2] |=>
		controller_stopped && !controller_running) else $error("stop lost");
	start_run_a: assert property (wr0 && pwdata[2:0] == 3'h2 |=>
		controller_running && !controller_stopped) else $error("no start");
	init_fetch_a: assert property (wr0 && pwdata[2:0] == 3'h1 |->
		##2 mem_req) else $error("no fetch after init");
	memory_error_off_a: assert property (mem_error |=>
		!receiver_enabled && !transmitter_enabled) else $error("on after memory_error");
	txerr_off_a: assert property (tx_status_valid &&
		(w2[31] || w2[30] || w2[26]) |=> !transmitter_enabled)
		else $error("tx on after tx error");
	io_stop_a: assert property (io_reset_a |=>
		controller_stopped ##1 !mem_req) else $error("io reset ignored");
	on_start_a: assert property ($rose(receiver_enabled) ||
		$rose(transmitter_enabled) |-> controller_running)
		else $error("on without start");
	even_addr_a: assert property (mem_req |-> !mem_addr[0])
		else $error("odd fetch address");
	poll_dmd_a: assert property (wr0 && pwdata[3:2] == 2'h2 &&
		transmitter_enabled |-> ##[1:3] tx_ring_poll) else $error("no poll");

	cover property ($rose(receiver_enabled));
	cover property (tx_ring_poll);
	cover property (mem_error ##1 !receiver_enabled);
endmodule // lccc_chk

bind lccc_top lccc_chk #(.POLL_CYCLES(POLL_CYCLES)) chk (.clock, .nrst,
	.io_reset_a, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.mem_req, .mem_addr, .mem_error, .tx_status_valid,
	.transmit_descriptor_word2, .receiver_enabled, .transmitter_enabled,
	.tx_ring_poll, .controller_running, .controller_stopped);

// >>> tb/lccc_mem.sv
module lccc_mem (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        mem_req,
	input  wire logic [23:0] mem_addr,
	input  wire logic [23:0] base,
	input  wire logic [15:0] mode,
	input  wire logic [1:0]  lag,
	input  wire logic        hang,
	output logic             mem_ack,
	output logic [15:0]      mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_ff;

	// answers a request after lag cycles, never while hung
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mem_ack <= 1'h0;
			mem_rdata <= 16'h0000;
			wait_ff <= 2'h0;
		end else if (mem_req && !mem_ack && !hang && wait_ff == lag) begin
			mem_ack <= 1'h1;
			mem_rdata <= mem_addr == {base[23:1], 1'h0} ? mode :
				~mem_addr[15:0];
			wait_ff <= 2'h0;
		end else begin
			mem_ack <= 1'h0;
			mem_rdata <= ~mem_rdata; // no stale word off the ack
			wait_ff <= mem_req && !mem_ack ? wait_ff + 2'h1 : 2'h0;
		end
	end
endmodule // lccc_mem

// >>> tb/lccc_top_tb.sv
`include "lccc_defs.vh"

module lccc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock, nrst, io_reset_a, psel, penable, pwrite, pready;
	logic        pslverr, mem_req, mem_ack, mem_error, tx_status_valid, hang;
	logic        receiver_enabled, transmitter_enabled, tx_ring_poll, er;
	logic        controller_running, controller_stopped;
	logic [31:0] paddr, pwdata, prdata, transmit_descriptor_word2, rd;
	logic [23:0] mem_addr, base;
	logic [15:0] mem_rdata, mode;
	logic [3:0]  bus_configuration, bc;
	logic [1:0]  lag;
	int          n_mismatch = 0, n_tests = 0, cyc = 0, n;

	lccc_top #(.POLL_CYCLES(16'h0100)) uut (.*);
	lccc_mem mem (.*);

	// command and status word once running
	function automatic logic [31:0] run_csr(logic [15:0] m);
		return 32'h0000_0103 | {26'h0, !m[0], !m[1], 4'h0};
	endfunction

	task automatic chk(string nm, logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(logic w, logic [31:0] a, d);
		int i;
		@(posedge clock);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		for (i = 0; i < 9 && pready !== 1'h1; i++) @(posedge clock);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (i == 9) chk("pready", 1, 0);
	endtask

	task automatic wr(logic [1:0] p, logic [31:0] d);
		apb(1, `LCCC_ADDR_PTR, p);
		apb(1, `LCCC_ADDR_SHARED, d);
	endtask

	task automatic rdr(logic [1:0] p);
		apb(1, `LCCC_ADDR_PTR, p);
		apb(0, `LCCC_ADDR_SHARED, 0);
	endtask

	task automatic txs(logic [31:0] w);
		@(posedge clock);
		transmit_descriptor_word2 <= w;
		tx_status_valid <= 1'h1;
		@(posedge clock);
		tx_status_valid <= 1'h0;
		repeat (2) @(posedge clock);
	endtask

	task give_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end

	// hang guard
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict;
		end
	end

	initial begin
		{nrst, io_reset_a, psel, penable, pwrite, mem_error} = 6'h00;
		{tx_status_valid, hang, lag, bc} = 8'h00;
		{paddr, pwdata, transmit_descriptor_word2} = 96'h0;
		base = 24'h00_0000;
		mode = 16'h0000;
		void'($urandom(29168));
		repeat (12) @(posedge clock);
		nrst <= 1'h1;
		rdr(0);
		chk("csr0", 32'h0000_0004, rd);
		apb(0, `LCCC_ADDR_SHARED + 32'h0000_0008, 0);
		chk("slverr", 1, er);
		bc = 4'($urandom);
		wr(3, bc);
		rdr(3);
		chk("bcfg", bc, rd);
		chk("bcfg_pin", bc, bus_configuration);
		for (int k = 0; k < 6; k++) begin
			base = 24'($urandom);
			mode = 16'(k % 4);
			lag = 2'($urandom);
			wr(1, base[15:0]);
			wr(2, base[23:16]);
			rdr(1);
			chk("addr_lo", base[15:1], rd[15:1]);
			rdr(2);
			chk("addr_hi", base[23:16], rd);
			wr(0, 1);
			for (n = 0; n < 9 && mem_req !== 1'h1; n++) @(posedge clock);
			chk("mem_addr", {base[23:1], 1'h0}, mem_addr);
			for (n = 0; n < 30 && rd[8] !== 1'h1; n++) rdr(0);
			chk("idone", 1, rd[8]);
			wr(0, 2);
			@(negedge clock);
			chk("rx_on", !mode[0], receiver_enabled);
			chk("tx_on", !mode[1], transmitter_enabled);
			wr(0, {26'h0, mode[0], mode[1], 4'h0});
			wr(1, ~base);
			rdr(1);
			chk("addr_run", 0, rd);
			rdr(0);
			chk("csr0_run", run_csr(mode), rd);
			case (k)
				0: begin
					wr(0, 8);
					for (n = 0; n < 4 && tx_ring_poll !== 1'h1; n++)
						@(posedge clock);
					chk("poll", 1, tx_ring_poll);
					rdr(0);
					chk("demand", 0, rd[3]);
				end
				2: begin
					mem_error <= 1'h1;
					@(posedge clock);
					mem_error <= 1'h0;
					repeat (2) @(posedge clock);
					chk("rx_memory_error", 0, receiver_enabled);
				end
				default: begin
					txs($urandom & 32'h3bff_ffff);
					chk("tx_keep", !mode[1], transmitter_enabled);
					txs($urandom & 32'h3bff_ffff |
						32'h1 << (k == 1 ? 31 : k == 4 ? 30 : 26));
					chk("tx_err", 0, transmitter_enabled);
					chk("rx_keep", !mode[0], receiver_enabled);
				end
			endcase
			if (k == 5) begin
				@(posedge clock);
				io_reset_a <= 1'h1;
				@(posedge clock);
				io_reset_a <= 1'h0;
			end else
				wr(0, k == 3 ? 7 : 4);
			rdr(0);
			chk("csr0_stop", 32'h0000_0004, rd);
		end
		hang <= 1'h1;
		wr(0, 1);
		repeat (520) @(posedge clock);
		chk("mem_req", 0, mem_req);
		rdr(0);
		chk("memory_error", 32'h0000_0801, rd & 32'h0000_0901);
		wr(0, 32'h0000_0800);
		rdr(0);
		chk("memory_error_clr", 32'h0000_0001, rd & 32'h0000_0901);
		give_verdict;
	end
endmodule // lccc_top_tb
